// ### tb/cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       slow,
   input  wire logic       irq_req_q,
   input  wire logic [7:0] irq_vec_q,
   input  wire logic [7:0] irq_lvl_q,
   input  wire logic       irq_fast_q,
   input  wire logic       xfer_req_q,
   input  wire logic       dma_req_q,
   output var  logic       cpu_ack,
   output var  logic       xfer_ack,
   output var  logic       dma_ack
);
   logic [7:0] last_vec;
   logic [7:0] last_lvl;
   logic       last_fast;
   int         cpu_n;
   int         xfer_n;
   int         dma_n;
   int         wait_q;
   // accept after a short or a slow delay, never two acks in a row
   always @(posedge clock)
   begin
      cpu_ack <= 1'b0;
      xfer_ack <= xfer_req_q && !xfer_ack && !reset;
      dma_ack <= dma_req_q && !dma_ack && !reset;
      wait_q <= (irq_req_q && !cpu_ack) ? wait_q + 1 : 0;
      if (reset)
         wait_q <= 0;
      else if (irq_req_q && !cpu_ack && wait_q >= (slow ? 3 : 0))
      begin
         cpu_ack <= 1'b1;
         cpu_n <= cpu_n + 1;
         last_vec <= irq_vec_q;
         last_lvl <= irq_lvl_q;
         last_fast <= irq_fast_q;
      end
      if (xfer_ack)
         xfer_n <= xfer_n + 1;
      if (dma_ack)
         dma_n <= dma_n + 1;
   end
endmodule // cpu_model
`default_nettype wire

// ### tb/icu_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module icu_asserts (
   input wire logic       clock,
   input wire logic       reset,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic [1:0] s_axi_rresp,
   input wire logic       cpu_ack,
   input wire logic       irq_req_q,
   input wire logic [7:0] irq_lvl_q,
   input wire logic       irq_fast_q,
   input wire logic       nmi_req_q,
   input wire logic       voltage_monitor_one,
   input wire logic [3:0] wake_q
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> !irq_req_q && !nmi_req_q && wake_q == 4'h0) else $error("outputs after reset");
   a_ack_drops_req: assert property (cpu_ack && irq_req_q |=> !irq_req_q)
      else $error("request held after ack");
   a_prio_nonzero: assert property (irq_req_q |-> irq_lvl_q != 8'h00)
      else $error("request at priority zero");
   a_fast_needs_req: assert property (irq_fast_q |-> irq_req_q)
      else $error("fast flag without request");
   a_write_readies: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
      else $error("ready high with write answer");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_sleep_wake: assert property (irq_req_q && $past(irq_req_q) |-> wake_q[0])
      else $error("no sleep wake with request");
   a_monitor_wake: assert property ($rose(voltage_monitor_one) |-> ##[1:4] wake_q[3:1] == 3'h7)
      else $error("no standby wake on monitor");
   c_fast_ack: cover property (cpu_ack && irq_fast_q);
   c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_nmi: cover property ($rose(nmi_req_q));
endmodule // icu_asserts
bind interrupt_controller_unit icu_asserts chk (.clock, .reset, .s_axi_awready, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .cpu_ack,
   .irq_req_q, .irq_lvl_q, .irq_fast_q, .nmi_req_q, .voltage_monitor_one, .wake_q);
`default_nettype wire

// ### tb/interrupt_controller_unit_bench.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_controller_unit_bench;
   logic clock, reset, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, eight_bit_timer_channels, wake_q;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] external_interrupt_pin, periph_a_level_groups;
   logic [5:0] nmi_src;
   logic nmi_pin, osc_stop, main_watchdog_err, independent_watchdog_err, ram_parity_err;
   logic voltage_monitor_one, voltage_monitor_two, nmi_req_q, xfer_req_q, dma_req_q;
   logic [7:0] coprocessor_edge_group, periph_b_edge_group, irq_vec_q, irq_lvl_q, xfer_vec_q;
   logic [23:0] periph_b_level_groups;
   logic [167:0] periph_a_src;
   logic cpu_ack, xfer_ack, dma_ack, irq_req_q, irq_fast_q;
   int fails, cmp_count, cycles, k, n0, x0, d0;
   assign {osc_stop, main_watchdog_err, independent_watchdog_err} = nmi_src[5:3];
   assign {voltage_monitor_one, voltage_monitor_two, ram_parity_err} = nmi_src[2:0];
   interrupt_controller_unit DUT (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .external_interrupt_pin, .nmi_pin, .osc_stop,
      .main_watchdog_err, .independent_watchdog_err, .voltage_monitor_one, .voltage_monitor_two,
      .ram_parity_err, .eight_bit_timer_channels, .coprocessor_edge_group, .periph_b_edge_group,
      .periph_b_level_groups, .periph_a_level_groups, .periph_a_src, .cpu_ack, .xfer_ack,
      .dma_ack, .irq_req_q, .irq_vec_q, .irq_lvl_q, .irq_fast_q, .nmi_req_q, .xfer_req_q,
      .xfer_vec_q, .dma_req_q, .wake_q);
   cpu_model model (.clock, .reset, .slow, .irq_req_q, .irq_vec_q, .irq_lvl_q, .irq_fast_q,
      .xfer_req_q, .dma_req_q, .cpu_ack, .xfer_ack, .dma_ack);
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t ns: %s", $time, msg);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check(32'(s_axi_bresp), 32'(er), "write answer");
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, exp, "read data");
      check(32'(s_axi_rresp), 32'(er), "read answer");
   endtask
   task pulse_pin(input int len);
      @(posedge clock) external_interrupt_pin[0] <= 1'b0;
      repeat (len) @(posedge clock);
      external_interrupt_pin[0] <= 1'b1;
      repeat (15) @(posedge clock);
   endtask
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         report_and_stop;
      end
   end
   initial
   begin
      {reset, external_interrupt_pin, nmi_pin, s_axi_wstrb} = {1'b1, 16'hffff, 1'b1, 4'hf};
      {slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, nmi_src, eight_bit_timer_channels} = 0;
      {coprocessor_edge_group, periph_b_edge_group, periph_b_level_groups} = 40'h0;
      {periph_a_level_groups, periph_a_src} = 184'h0;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      for (k = 0; k < 21; k++)
         periph_a_src[8*k +: 8] <= 8'(k + 16);
      for (k = 15; k < 22; k++)
         rd(12'(128 + 4*k), (k < 16 || k == 18 || k == 19 || k == 20) ? 32'(k + 16) : 32'h0,
            (k < 16 || (k > 17 && k < 21)) ? 2'h0 : 2'h2);
      wr(12'hffc, 32'h0000_0000, 2'h2);
      wr(12'h740, 32'h0000_0103, 2'h0);
      wr(12'h100, 32'h0000_0004, 2'h0);
      repeat (8) @(posedge clock);
      check(32'({model.last_lvl, model.last_vec}), 32'h0000_03d0, "configurable vector");
      for (k = 0; k < 2; k++)
      begin
         wr(12'h100, k ? 32'h0000_0000 : 32'h0000_00ff, 2'h0);
         repeat (6) @(posedge clock);
         check(32'(irq_req_q), 32'h0, "no source selected");
      end
      slow <= 1'b1;
      wr(12'h468, 32'h0000_0105, 2'h0);
      wr(12'h46c, 32'h0000_0100, 2'h0);
      wr(12'h000, 32'h0000_0003, 2'h0);
      repeat (12) @(posedge clock);
      check(32'({model.last_lvl, model.last_vec}), 32'h0000_051a, "software vector");
      check(32'(irq_req_q), 32'h0, "priority zero silent");
      rd(12'h000, 32'h0000_0002, 2'h0);
      slow <= 1'b0;
      wr(12'h500, 32'h0000_0108, 2'h0);
      for (k = 0; k < 4; k++)
      begin
         wr(12'h004, 32'(k), 2'h0);
         n0 = model.cpu_n;
         pulse_pin(10);
         check(k == 0 ? 32'(model.cpu_n != n0) : 32'(model.cpu_n - n0),
            k == 3 ? 32'h2 : 32'h1, "pin trigger");
      end
      wr(12'h008, 32'h0000_0001, 2'h0);
      wr(12'h004, 32'h0000_0001, 2'h0);
      n0 = model.cpu_n;
      pulse_pin(1);
      check(32'(model.cpu_n - n0), 32'h0, "glitch filtered");
      wr(12'h018, 32'h0000_0140, 2'h0);
      pulse_pin(10);
      check(32'({model.last_fast, model.last_vec}), 32'h0000_0140, "fast vector");
      wr(12'h500, 32'h0000_0308, 2'h0);
      wr(12'h01c, 32'h0000_0140, 2'h0);
      {x0, d0} = {model.xfer_n, model.dma_n};
      pulse_pin(10);
      check(32'({model.xfer_n != x0, model.dma_n != d0}), 32'h3, "engine starts");
      @(posedge clock) coprocessor_edge_group <= 8'h08;
      @(posedge clock) coprocessor_edge_group <= 8'h00;
      rd(12'h040, 32'h0000_0008, 2'h0);
      wr(12'h040, 32'h0000_0008, 2'h0);
      rd(12'h040, 32'h0000_0000, 2'h0);
      wr(12'h5b8, 32'h0000_0102, 2'h0);
      wr(12'h070, 32'h0000_0004, 2'h0);
      @(posedge clock) periph_b_level_groups <= 24'h04_0000;
      repeat (8) @(posedge clock);
      rd(12'h050, 32'h0000_0004, 2'h0);
      check(32'(model.last_vec), 32'h0000_006e, "group request");
      @(posedge clock) periph_b_level_groups <= 24'h00_0000;
      repeat (6) @(posedge clock);
      check(32'(irq_req_q), 32'h0, "group request dropped");
      wr(12'h00c, 32'h0000_0001, 2'h0);
      wr(12'h014, 32'h0000_0002, 2'h0);
      @(posedge clock) nmi_pin <= 1'b0;
      repeat (4) @(posedge clock);
      rd(12'h010, 32'h0000_0000, 2'h0);
      @(posedge clock) nmi_pin <= 1'b1;
      @(posedge clock) nmi_src <= 6'h3f;
      @(posedge clock) nmi_src <= 6'h00;
      repeat (4) @(posedge clock);
      check(32'(nmi_req_q), 32'h1, "nmi request");
      rd(12'h010, 32'h0000_007f, 2'h0);
      wr(12'h010, 32'h0000_007f, 2'h0);
      rd(12'h010, 32'h0000_0000, 2'h0);
      report_and_stop;
   end
endmodule // interrupt_controller_unit_bench
`default_nettype wire

// ### verilog/intc_map.vh
`ifndef INTC_MAP_VH
`define INTC_MAP_VH
// register byte offsets
`define OFS_SWINT      12'h000
`define OFS_PIN_MODE   12'h004
`define OFS_FILT_EN    12'h008
`define OFS_NMI_CTL    12'h00C
`define OFS_NMI_STAT   12'h010
`define OFS_NMI_EN     12'h014
`define OFS_FAST_CTL   12'h018
`define OFS_DMA_CTL    12'h01C
`define OFS_DEEP_MASK  12'h020
`define OFS_WAKE_STAT  12'h024
`define OFS_CPU_STAT   12'h028
`define OFS_GRP_REQ    12'h040
`define OFS_GRP_EN     12'h060
`define OFS_CFG_REQ    12'h080
`define OFS_CFG_SEL    12'h100
`define OFS_VEC_CTL    12'h400
// counts and limits
`define NUM_GRP        7
`define NUM_CFG        48
`define CFG_REQ_LAST   5'h14
`define CFG_REQ_GAP_LO 5'h10
`define CFG_REQ_GAP_HI 5'h11
`define NUM_A_SRC      168
`define SEL_NONE_LO    8'h00
`define SEL_NONE_HI    8'hFF
// vector numbers
`define VEC_SW0        8'h1A
`define VEC_PIN_BASE   8'h40
`define VEC_GRP_BASE   8'h6A
`define VEC_CFG_BASE   8'hD0
// pin trigger modes
`define MODE_LOW       2'h0
`define MODE_FALL      2'h1
`define MODE_RISE      2'h2
`define MODE_BOTH      2'h3
// bus answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ### verilog/interrupt_controller_unit.v
`include "intc_map.vh"
`timescale 1ns/10ps
`default_nettype none
module interrupt_controller_unit (
   input  wire          clock,
   input  wire          reset,
   input  wire [11:0]   s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [11:0]   s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   input  wire [15:0]   external_interrupt_pin,
   input  wire          nmi_pin,
   input  wire          osc_stop,
   input  wire          main_watchdog_err,
   input  wire          independent_watchdog_err,
   input  wire          voltage_monitor_one,
   input  wire          voltage_monitor_two,
   input  wire          ram_parity_err,
   input  wire [3:0]    eight_bit_timer_channels,
   input  wire [7:0]    coprocessor_edge_group,
   input  wire [7:0]    periph_b_edge_group,
   input  wire [23:0]   periph_b_level_groups,
   input  wire [15:0]   periph_a_level_groups,
   input  wire [167:0]  periph_a_src,
   input  wire          cpu_ack,
   input  wire          xfer_ack,
   input  wire          dma_ack,
   output reg           irq_req_q,
   output reg  [7:0]    irq_vec_q,
   output reg  [7:0]    irq_lvl_q,
   output reg           irq_fast_q,
   output reg           nmi_req_q,
   output reg           xfer_req_q,
   output reg  [7:0]    xfer_vec_q,
   output reg           dma_req_q,
   output reg  [3:0]    wake_q
);
   reg  [7:0]   ipr_q [0:255];
   reg  [1:0]   tgt_q [0:255];
   reg  [7:0]   sel_q [0:`NUM_CFG-1];
   reg  [1:0]   sw_pend_q;
   reg  [31:0]  pin_mode_q;
   reg  [16:0]  filt_en_q;
   reg          nmi_rise_q;
   reg  [6:0]   nmi_stat_q;
   reg  [6:0]   nmi_en_q;
   reg  [8:0]   fast_ctl_q;
   reg  [8:0]   dma_ctl_q;
   reg  [15:0]  deep_mask_q;
   reg  [15:0]  edge_lat_q;
   reg  [55:0]  grp_en_q;
   reg  [15:0]  pin_pend_q;
   reg  [50:0]  flt_sh_q;
   reg  [16:0]  flt_q;
   reg  [16:0]  raw_q;
   reg  [16:0]  prev_q;
   reg  [11:0]  aw_addr_q;
   reg          aw_have_q;
   reg  [31:0]  w_data_q;
   reg  [3:0]   w_strb_q;
   reg          w_have_q;
   wire [16:0]  pin_raw = {nmi_pin, external_interrupt_pin};
   wire [16:0]  sig = (filt_en_q & flt_q) | (~filt_en_q & raw_q);
   wire [55:0]  grp_stat = {periph_a_level_groups, periph_b_level_groups, edge_lat_q};
   wire         nmi_edge = nmi_rise_q ? (~prev_q[16] & sig[16]) : (prev_q[16] & ~sig[16]);
   wire [6:0]   nmi_ev = {ram_parity_err, voltage_monitor_two, voltage_monitor_one,
                          independent_watchdog_err, main_watchdog_err, osc_stop, nmi_edge};
   wire         aw_take = s_axi_awvalid & s_axi_awready;
   wire         w_take = s_axi_wvalid & s_axi_wready;
   wire         do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
   wire         ar_take = s_axi_arvalid & s_axi_arready;
   wire         rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
   wire [31:0]  wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire [32:0]  wr_cur = rd(aw_addr_q);
   wire [31:0]  wv = (wr_cur[31:0] & ~wmask) | (w_data_q & wmask);
   wire [31:0]  w1 = w_data_q & wmask;
   wire [32:0]  rd_now = rd(s_axi_araddr);
   reg  [15:0]  pin_req;
   reg  [15:0]  edge_hit;
   reg  [6:0]   grp_req;
   reg  [47:0]  cfg_req;
   reg  [255:0] req;
   reg          best_ok;
   reg  [7:0]   best_v;
   reg  [7:0]   best_p;
   integer      i;
   genvar       g;

   function ackd;
      input [7:0] v;
      begin
         ackd = (cpu_ack & irq_vec_q == v) | (xfer_ack & xfer_vec_q == v);
      end
   endfunction

   function [32:0] rd;
      input [11:0] a;
      reg   [4:0]  k;
      begin
         k = a[6:2];
         rd = {1'b0, 32'h0000_0000};
         if (a[11:10] == 2'b01)
            rd = {1'b1, 22'h00_0000, tgt_q[a[9:2]], ipr_q[a[9:2]]};
         else if (a[11:8] == 4'h1)
         begin
            if (a[7:2] < `NUM_CFG)
               rd = {1'b1, 24'h00_0000, sel_q[a[7:2]]};
         end
         else if (a[11:7] == 5'h01)
         begin
            if (k <= `CFG_REQ_LAST && (k < `CFG_REQ_GAP_LO || k > `CFG_REQ_GAP_HI))
               rd = {1'b1, 24'h00_0000, periph_a_src[k*8 +: 8]};
         end
         else if (a >= `OFS_GRP_REQ && a < `OFS_GRP_REQ + 12'h01C && a[1:0] == 2'h0)
            rd = {1'b1, 24'h00_0000, grp_stat[(a[4:2]) * 8 +: 8]};
         else if (a >= `OFS_GRP_EN && a < `OFS_GRP_EN + 12'h01C && a[1:0] == 2'h0)
            rd = {1'b1, 24'h00_0000, grp_en_q[(a[4:2]) * 8 +: 8]};
         else
            case (a)
               `OFS_SWINT:     rd = {1'b1, 30'h0000_0000, sw_pend_q};
               `OFS_PIN_MODE:  rd = {1'b1, pin_mode_q};
               `OFS_FILT_EN:   rd = {1'b1, 15'h0000, filt_en_q};
               `OFS_NMI_CTL:   rd = {1'b1, 31'h0000_0000, nmi_rise_q};
               `OFS_NMI_STAT:  rd = {1'b1, 25'h000_0000, nmi_stat_q};
               `OFS_NMI_EN:    rd = {1'b1, 25'h000_0000, nmi_en_q};
               `OFS_FAST_CTL:  rd = {1'b1, 23'h00_0000, fast_ctl_q};
               `OFS_DMA_CTL:   rd = {1'b1, 23'h00_0000, dma_ctl_q};
               `OFS_DEEP_MASK: rd = {1'b1, 16'h0000, deep_mask_q};
               `OFS_WAKE_STAT: rd = {1'b1, 28'h000_0000, wake_q};
               `OFS_CPU_STAT:  rd = {1'b1, 15'h0000, irq_req_q, irq_lvl_q, irq_vec_q};
               default:        rd = {1'b0, 32'h0000_0000};
            endcase
      end
   endfunction

   // noise filters: output moves only after three equal samples
   generate
      for (g = 0; g < 17; g = g + 1)
      begin : filt
         always @(posedge clock)
         begin
            if (reset)
            begin
               flt_sh_q[g*3 +: 3] <= 3'h7;
               flt_q[g] <= 1'b1;
            end
            else
            begin
               flt_sh_q[g*3 +: 3] <= {flt_sh_q[g*3 +: 2], pin_raw[g]};
               if (flt_sh_q[g*3 +: 3] == 3'h7 || flt_sh_q[g*3 +: 3] == 3'h0)
                  flt_q[g] <= flt_sh_q[g*3];
            end
         end
      end
   endgenerate

   // request gathering and arbitration
   always @*
   begin
      req = 256'h0;
      best_ok = 1'b0;
      best_v = 8'h00;
      best_p = 8'h00;
      for (i = 0; i < 16; i = i + 1)
      begin
         edge_hit[i] = (pin_mode_q[i*2 +: 2] == `MODE_FALL & prev_q[i] & ~sig[i])
                     | (pin_mode_q[i*2 +: 2] == `MODE_RISE & ~prev_q[i] & sig[i])
                     | (pin_mode_q[i*2 +: 2] == `MODE_BOTH & (prev_q[i] ^ sig[i]));
         pin_req[i] = (pin_mode_q[i*2 +: 2] == `MODE_LOW) ? ~sig[i] : pin_pend_q[i];
         req[`VEC_PIN_BASE + i] = pin_req[i];
      end
      for (i = 0; i < `NUM_GRP; i = i + 1)
      begin
         grp_req[i] = |(grp_stat[i*8 +: 8] & grp_en_q[i*8 +: 8]);
         req[`VEC_GRP_BASE + i] = grp_req[i];
      end
      for (i = 0; i < `NUM_CFG; i = i + 1)
      begin
         cfg_req[i] = sel_q[i] != `SEL_NONE_LO && sel_q[i] != `SEL_NONE_HI
                    && sel_q[i] < `NUM_A_SRC && periph_a_src[sel_q[i]];
         req[`VEC_CFG_BASE + i] = cfg_req[i];
      end
      req[`VEC_SW0] = sw_pend_q[0];
      req[`VEC_SW0 + 1] = sw_pend_q[1];
      for (i = 0; i < 256; i = i + 1)
         if (req[i] && tgt_q[i] != 2'h0 && ipr_q[i] > best_p)
         begin
            best_ok = 1'b1;
            best_v = i[7:0];
            best_p = ipr_q[i];
         end
   end

   always @(posedge clock)
   begin
      if (reset)
      begin
         raw_q <= 17'h1_FFFF;
         prev_q <= 17'h1_FFFF;
         pin_pend_q <= 16'h0000;
         edge_lat_q <= 16'h0000;
         nmi_stat_q <= 7'h00;
         irq_req_q <= 1'b0;
         irq_vec_q <= 8'h00;
         irq_lvl_q <= 8'h00;
         irq_fast_q <= 1'b0;
         nmi_req_q <= 1'b0;
         xfer_req_q <= 1'b0;
         xfer_vec_q <= 8'h00;
         dma_req_q <= 1'b0;
         wake_q <= 4'h0;
      end
      else
      begin
         raw_q <= pin_raw;
         prev_q <= sig;
         for (i = 0; i < 16; i = i + 1)
            pin_pend_q[i] <= edge_hit[i] | (pin_pend_q[i] & ~ackd(`VEC_PIN_BASE + i[7:0])
                           & pin_mode_q[i*2 +: 2] != `MODE_LOW);
         edge_lat_q <= {periph_b_edge_group, coprocessor_edge_group}
                     | (edge_lat_q & ~({16{do_wr && aw_addr_q == `OFS_GRP_REQ}}
                     & {8'h00, w1[7:0]})
                     & ~({16{do_wr && aw_addr_q == `OFS_GRP_REQ + 12'h004}}
                     & {w1[7:0], 8'h00}));
         nmi_stat_q <= nmi_ev | (nmi_stat_q & ~({7{do_wr && aw_addr_q == `OFS_NMI_STAT}}
                     & w1[6:0]));
         nmi_req_q <= |(nmi_stat_q & nmi_en_q);
         irq_req_q <= best_ok & tgt_q[best_v][0] & ~cpu_ack;
         irq_vec_q <= best_v;
         irq_lvl_q <= best_p;
         irq_fast_q <= best_ok & tgt_q[best_v][0] & ~cpu_ack & fast_ctl_q[8]
                     & fast_ctl_q[7:0] == best_v;
         xfer_req_q <= best_ok & tgt_q[best_v][1] & ~xfer_ack;
         xfer_vec_q <= best_v;
         dma_req_q <= dma_ctl_q[8] & req[dma_ctl_q[7:0]] & ~dma_ack;
         wake_q[0] <= best_ok | nmi_req_q;
         wake_q[1] <= nmi_stat_q[0] | (|pin_req) | voltage_monitor_one | voltage_monitor_two
                    | osc_stop | independent_watchdog_err | (|eight_bit_timer_channels);
         wake_q[2] <= nmi_stat_q[0] | (|pin_req) | voltage_monitor_one | voltage_monitor_two
                    | independent_watchdog_err;
         wake_q[3] <= nmi_stat_q[0] | (|(pin_req & deep_mask_q)) | voltage_monitor_one
                    | voltage_monitor_two;
      end
   end

   // register bus slave
   always @(posedge clock)
   begin
      if (reset)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         sw_pend_q <= 2'h0;
         pin_mode_q <= 32'h0000_0000;
         filt_en_q <= 17'h0_0000;
         nmi_rise_q <= 1'b0;
         nmi_en_q <= 7'h00;
         fast_ctl_q <= 9'h000;
         dma_ctl_q <= 9'h000;
         deep_mask_q <= 16'h0000;
         grp_en_q <= 56'h00_0000_0000_0000;
         for (i = 0; i < 256; i = i + 1)
         begin
            ipr_q[i] <= 8'h00;
            tgt_q[i] <= 2'h0;
         end
         for (i = 0; i < `NUM_CFG; i = i + 1)
            sel_q[i] <= `SEL_NONE_LO;
      end
      else
      begin
         aw_have_q <= ~do_wr & (aw_have_q | aw_take);
         w_have_q <= ~do_wr & (w_have_q | w_take);
         s_axi_awready <= ~(~do_wr & (aw_have_q | aw_take));
         s_axi_wready <= ~(~do_wr & (w_have_q | w_take));
         if (aw_take)
            aw_addr_q <= s_axi_awaddr;
         if (w_take)
         begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         s_axi_bvalid <= do_wr | (s_axi_bvalid & ~s_axi_bready);
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid <= rvalid_d;
         if (ar_take)
         begin
            s_axi_rdata <= rd_now[31:0];
            s_axi_rresp <= rd_now[32] ? `RESP_OKAY : `RESP_SLVERR;
         end
         sw_pend_q[0] <= (do_wr && aw_addr_q == `OFS_SWINT && w1[0])
                       | (sw_pend_q[0] & ~ackd(`VEC_SW0));
         sw_pend_q[1] <= (do_wr && aw_addr_q == `OFS_SWINT && w1[1])
                       | (sw_pend_q[1] & ~ackd(`VEC_SW0 + 8'h01));
         if (do_wr)
         begin
            s_axi_bresp <= wr_cur[32] ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_addr_q[11:10] == 2'b01)
            begin
               ipr_q[aw_addr_q[9:2]] <= wv[7:0];
               tgt_q[aw_addr_q[9:2]] <= wv[9:8];
            end
            else if (aw_addr_q[11:8] == 4'h1 && aw_addr_q[7:2] < `NUM_CFG)
               sel_q[aw_addr_q[7:2]] <= wv[7:0];
            else if (wr_cur[32] && aw_addr_q >= `OFS_GRP_EN
                     && aw_addr_q < `OFS_GRP_EN + 12'h01C)
               grp_en_q[(aw_addr_q[4:2]) * 8 +: 8] <= wv[7:0];
            else
               case (aw_addr_q)
                  `OFS_PIN_MODE:  pin_mode_q <= wv;
                  `OFS_FILT_EN:   filt_en_q <= wv[16:0];
                  `OFS_NMI_CTL:   nmi_rise_q <= wv[0];
                  `OFS_NMI_EN:    nmi_en_q <= wv[6:0];
                  `OFS_FAST_CTL:  fast_ctl_q <= wv[8:0];
                  `OFS_DMA_CTL:   dma_ctl_q <= wv[8:0];
                  `OFS_DEEP_MASK: deep_mask_q <= wv[15:0];
                  default:        deep_mask_q <= deep_mask_q;
               endcase
         end
      end
   end
endmodule // interrupt_controller_unit
`default_nettype wire
